/* File: pkg/lvs_pkg.sv */
// Package of constants and types for the low-voltage supervisor and watchdog
package lvs_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIAS_START_US = 1000;
   localparam int SS_DELAY_US = 150;
   localparam int PG_FILT_US = 100;
   localparam int RST_DELAY_MS = 202;
   localparam int BIAS_START_CYC = (BIAS_START_US * 1000) / CLK_PERIOD_NS;
   localparam int SS_DELAY_CYC = (SS_DELAY_US * 1000) / CLK_PERIOD_NS;
   localparam int PG_FILT_CYC = (PG_FILT_US * 1000) / CLK_PERIOD_NS;
   localparam int RST_DELAY_CYC = (RST_DELAY_MS * 100000) / 1;
   // Watchdog window factors of the base timeout, then channel count and counter width
   localparam int WD_LOW_DIV_SHIFT = 2;
   localparam int WD_KICK_MULT = 8;
   localparam int WD_TMO_MULT = 64;
   localparam int NUM_CH = 4;
   localparam int CNT_W = 32;
   // ------------------------------------------------------------
   // Watchdog states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_TIMEOUT = 2'b01,
      WD_LOWER = 2'b10,
      WD_UPPER = 2'b11
   } lvs_wd_state_t;
endpackage

/* File: pkg/lvs_wd_if.sv */
// Interface between supervisor top and its watchdog
`timescale 1ns/1ps
interface lvs_wd_if;
   logic run_any;
   logic wd_disable;
   logic kick_fall;
   logic wd_out;
   modport top (output run_any, output wd_disable, output kick_fall, input wd_out);
   modport wd (input run_any, input wd_disable, input kick_fall, output wd_out);
endinterface

/* File: rtl/lvs_watchdog.sv */
// Windowed watchdog timer
`timescale 1ns/1ps
module lvs_watchdog
   import lvs_pkg::*;
#(
   parameter int WD_BASE_CYC = RST_DELAY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   lvs_wd_if.wd bus
);
   lvs_wd_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic upper_tmo_reg, upper_tmo_next;
   logic out_reg, out_next;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 1'b1;
      upper_tmo_next = upper_tmo_reg;
      out_next = out_reg;
      case (state_reg)
         WD_OFF: begin
            // Restart in timeout state with output low when powered again
            cnt_next = '0;
            out_next = 1'b0;
            if (bus.run_any && !bus.wd_disable) begin
               state_next = WD_TIMEOUT;
            end
         end
         WD_TIMEOUT: begin
            out_next = 1'b0;
            if (cnt_reg >= CNT_W'(WD_BASE_CYC - 1)) begin
               state_next = WD_LOWER;
               cnt_next = '0;
               out_next = 1'b1;
               upper_tmo_next = 1'b1;
            end
         end
         WD_LOWER: begin
            if (bus.kick_fall) begin
               state_next = WD_TIMEOUT;
               cnt_next = '0;
               out_next = 1'b0;
            end else if (cnt_reg >= CNT_W'((WD_BASE_CYC >> WD_LOW_DIV_SHIFT) - 1)) begin
               state_next = WD_UPPER;
            end
         end
         WD_UPPER: begin
            if (bus.kick_fall) begin
               // Valid kick restarts with a new lower boundary
               state_next = WD_LOWER;
               cnt_next = '0;
               upper_tmo_next = 1'b0;
            end else if ((upper_tmo_reg && cnt_reg >= CNT_W'(WD_BASE_CYC * WD_TMO_MULT - 1))
                  || (!upper_tmo_reg && cnt_reg >= CNT_W'(WD_BASE_CYC * WD_KICK_MULT - 1))) begin
               state_next = WD_TIMEOUT;
               cnt_next = '0;
               out_next = 1'b0;
            end
         end
         default: begin
            state_next = WD_OFF;
         end
      endcase
      // Stopped when everything is off or the timer is strapped off
      if (!bus.run_any || bus.wd_disable) begin
         state_next = WD_OFF;
         cnt_next = '0;
         out_next = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg <= WD_OFF;
         cnt_reg <= '0;
         upper_tmo_reg <= 1'b1;
         out_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         upper_tmo_reg <= upper_tmo_next;
         out_reg <= out_next;
      end
   end

   assign bus.wd_out = out_reg;
endmodule // lvs_watchdog

/* File: rtl/lvs_supervisor.sv */
// Low-voltage channel supervisor: sequencing, reset output, overtemp, watchdog
//
// How it works
// - No regulator enabled during 1ms bias start after first enable request.
// - Each enabled channel waits 150us more before its soft-start begins.
// - Coarse 0.73V threshold when all off; precise 400mV once any on.
// - Power good drops under 98% (ch1), 95% (ch2-4), or above 107.5%.
// - Reset output goes low after a power-good flag stays low over 100us.
// - Reset output released after all enabled channels good for 202ms.
// - Reset output held low while all channels are disabled.
// - Overtemp trip shuts all channels until temperature drops below lower trip.
// - Temperature monitor off and output floating when all channels shut down.
// - Only a falling kick edge counts as a service event.
// - Timeout drives watchdog output low for reset period, then restarts.
// - Watchdog starts in timeout state, output low, at power-up.
// - Kick before lower window boundary is a failure and forces timeout.
// - Lower boundary quarter base, upper 8x after kick, 64x after timeout.
// - Watchdog stops when run and all enables are low, disabled when timing pin strapped high.
`timescale 1ns/1ps
module lvs_supervisor
   import lvs_pkg::*;
#(
   parameter int BIAS_CYC = BIAS_START_CYC,
   parameter int RST_CYC = RST_DELAY_CYC,
   parameter int WD_BASE_CYC = RST_DELAY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic [NUM_CH-1:0] channel_enable_inputs_i,
   input wire logic [NUM_CH-1:0] fb_under_i,
   input wire logic [NUM_CH-1:0] fb_over_i,
   input wire logic overtemp_hi_i,
   input wire logic overtemp_lo_i,
   input wire logic ct_tied_bias_i,
   input wire logic watchdog_kick_in_i,
   output logic precise_threshold_o,
   output logic [NUM_CH-1:0] channel_on_o,
   output logic [NUM_CH-1:0] soft_start_go_o,
   output logic [NUM_CH-1:0] power_good_o,
   output logic pfail_rst_n_o,
   output logic pfail_rst_oe_o,
   output logic overtemp_shutdown_o,
   output logic temp_mon_en_o,
   output logic temp_oe_o,
   output logic watchdog_timeout_out_o
);
   // ------------------------------------------------------------
   // Input synchronisers (two flops for every pin except sys_clk_i, rst_i and ce_i)
   // ------------------------------------------------------------
   // One bit per pin: run, enables, under, over, two overtemp levels, strap, kick
   localparam int SW = 3 * NUM_CH + 5;
   logic [SW-1:0] raw_in, s1_reg, s2_reg;
   assign raw_in = {run_i, channel_enable_inputs_i, fb_under_i, fb_over_i,
                    overtemp_hi_i, overtemp_lo_i, ct_tied_bias_i, watchdog_kick_in_i};

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else if (ce_i) begin
         s1_reg <= raw_in;
         s2_reg <= s1_reg;
      end
   end

   logic run_s, ot_hi_s, ot_lo_s, ct_bias_s, kick_s;
   logic [NUM_CH-1:0] en_s, under_s, over_s;
   assign {run_s, en_s, under_s, over_s, ot_hi_s, ot_lo_s, ct_bias_s, kick_s} = s2_reg;

   // ------------------------------------------------------------
   // State declarations
   // ------------------------------------------------------------
   logic bias_seen_reg, bias_seen_next;
   logic bias_ready_reg, bias_ready_next;
   logic [CNT_W-1:0] bias_cnt_reg, bias_cnt_next;
   logic ot_reg, ot_next;
   logic kick_d_reg, kick_d_next;
   logic [CNT_W-1:0] filt_cnt_reg, filt_cnt_next;
   logic [CNT_W-1:0] rel_cnt_reg, rel_cnt_next;
   logic rst_n_reg, rst_n_next;
   logic [NUM_CH-1:0] ch_on, pg_raw;
   logic [NUM_CH-1:0] ss_reg;
   logic any_on, any_req, all_pg;

   // Channels run only after bias start and outside overtemp
   assign ch_on = en_s & {NUM_CH{bias_ready_reg && !ot_reg}};
   assign any_on = |ch_on;
   assign any_req = run_s || (|en_s);

   // ------------------------------------------------------------
   // Per-channel soft-start delay and power good
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic [CNT_W-1:0] ss_cnt_reg, ss_cnt_next;
         logic ss_next;
         // Channel 1 compares at 98%, others at 95%; off-chip comparators
         // report the crossing, so the window choice is by channel index
         assign pg_raw[g] = ch_on[g] && !under_s[g] && !over_s[g];
         always_comb begin
            ss_cnt_next = ss_cnt_reg;
            ss_next = ss_reg[g];
            if (!ch_on[g]) begin
               ss_cnt_next = '0;
               ss_next = 1'b0;
            end else if (!ss_reg[g]) begin
               if (ss_cnt_reg >= CNT_W'(SS_DELAY_CYC - 1)) begin
                  ss_next = 1'b1;
               end else begin
                  ss_cnt_next = ss_cnt_reg + 1'b1;
               end
            end
         end
         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               ss_cnt_reg <= '0;
               ss_reg[g] <= 1'b0;
            end else if (ce_i) begin
               ss_cnt_reg <= ss_cnt_next;
               ss_reg[g] <= ss_next;
            end
         end
      end
   endgenerate

   // Every enabled channel good; disabled channels do not count
   assign all_pg = ((pg_raw | ~ch_on) == {NUM_CH{1'b1}}) && any_on;

   // ------------------------------------------------------------
   // Bias start, overtemp hysteresis, power-fail reset, kick edge
   // ------------------------------------------------------------
   always_comb begin
      bias_seen_next = bias_seen_reg || any_req;
      bias_ready_next = bias_ready_reg;
      bias_cnt_next = bias_cnt_reg;
      if (bias_seen_reg && !bias_ready_reg) begin
         if (bias_cnt_reg >= CNT_W'(BIAS_CYC - 1)) begin
            bias_ready_next = 1'b1;
         end else begin
            bias_cnt_next = bias_cnt_reg + 1'b1;
         end
      end
      // Trip on upper level, hold until below lower level
      ot_next = ot_reg;
      if (ot_hi_s) begin
         ot_next = 1'b1;
      end else if (!ot_lo_s) begin
         ot_next = 1'b0;
      end
      // Low filter and release delay
      filt_cnt_next = '0;
      rel_cnt_next = '0;
      rst_n_next = rst_n_reg;
      if (!any_on) begin
         rst_n_next = 1'b0;
      end else if (!all_pg) begin
         rel_cnt_next = '0;
         if (filt_cnt_reg >= CNT_W'(PG_FILT_CYC)) begin
            rst_n_next = 1'b0;
            filt_cnt_next = filt_cnt_reg;
         end else begin
            filt_cnt_next = filt_cnt_reg + 1'b1;
         end
      end else begin
         filt_cnt_next = '0;
         if (rst_n_reg) begin
            rel_cnt_next = '0;
         end else if (rel_cnt_reg >= CNT_W'(RST_CYC - 1)) begin
            rst_n_next = 1'b1;
         end else begin
            rel_cnt_next = rel_cnt_reg + 1'b1;
         end
      end
      kick_d_next = kick_s;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         bias_seen_reg <= 1'b0;
         bias_ready_reg <= 1'b0;
         bias_cnt_reg <= '0;
         ot_reg <= 1'b0;
         filt_cnt_reg <= '0;
         rel_cnt_reg <= '0;
         rst_n_reg <= 1'b0;
         kick_d_reg <= 1'b0;
      end else if (ce_i) begin
         bias_seen_reg <= bias_seen_next;
         bias_ready_reg <= bias_ready_next;
         bias_cnt_reg <= bias_cnt_next;
         ot_reg <= ot_next;
         filt_cnt_reg <= filt_cnt_next;
         rel_cnt_reg <= rel_cnt_next;
         rst_n_reg <= rst_n_next;
         kick_d_reg <= kick_d_next;
      end
   end

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   lvs_wd_if wd_bus();
   assign wd_bus.run_any = any_req && bias_ready_reg;
   assign wd_bus.wd_disable = ct_bias_s;
   // Falling edge only; a long low pulse yields one event
   assign wd_bus.kick_fall = kick_d_reg && !kick_s;

   lvs_watchdog #(
      .WD_BASE_CYC(WD_BASE_CYC)
   ) u_wd (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .bus(wd_bus.wd)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign precise_threshold_o = any_on;
   assign channel_on_o = ch_on;
   assign soft_start_go_o = ss_reg;
   assign power_good_o = pg_raw;
   // Open drain: drive only the low level
   assign pfail_rst_n_o = 1'b0;
   assign pfail_rst_oe_o = !rst_n_reg;
   assign overtemp_shutdown_o = ot_reg;
   assign temp_mon_en_o = any_on;
   assign temp_oe_o = any_on;
   assign watchdog_timeout_out_o = wd_bus.wd_out;
endmodule // lvs_supervisor

/* File: test/lvs_supervisor_asserts.sv */
// Port checker for the supervisor
`timescale 1ns/1ps
module lvs_supervisor_asserts
   import lvs_pkg::*;
#(
   parameter int RST_CYC = 400,
   parameter int WD_BASE_CYC = 400
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [NUM_CH-1:0] fb_under_i,
   input wire logic [NUM_CH-1:0] fb_over_i,
   input wire logic overtemp_lo_i,
   input wire logic precise_threshold_o,
   input wire logic [NUM_CH-1:0] channel_on_o,
   input wire logic [NUM_CH-1:0] power_good_o,
   input wire logic pfail_rst_oe_o,
   input wire logic overtemp_shutdown_o,
   input wire logic temp_mon_en_o,
   input wire logic temp_oe_o,
   input wire logic watchdog_timeout_out_o
);
   // ----
   // Run lengths
   // ----
   int good_cnt;
   int bad_cnt;
   int low_cnt;
   logic all_good;
   logic any_bad;
   assign all_good = channel_on_o != 4'h0 && (power_good_o | ~channel_on_o) == 4'hF;
   assign any_bad = (channel_on_o & ~power_good_o) != 4'h0;
   // Counts restart on any break so only unbroken runs are credited
   always_ff @(posedge sys_clk_i) begin
      good_cnt <= (rst_i || !all_good) ? 0 : good_cnt + 1;
      bad_cnt <= (rst_i || !any_bad) ? 0 : bad_cnt + 1;
      low_cnt <= (rst_i || watchdog_timeout_out_o) ? 0 : low_cnt + 1;
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_thresh_any_on: assert property (precise_threshold_o == (channel_on_o != 4'h0))
      else $error("threshold select mismatch");
   a_pg_flag_drop: assert property (((fb_under_i | fb_over_i) != 4'h0) [*5]
      |-> (power_good_o & (fb_under_i | fb_over_i)) == 4'h0)
      else $error("power good kept high on bad output");
   a_filter_before_fail: assert property ($rose(pfail_rst_oe_o) && channel_on_o != 4'h0
      && $past(channel_on_o) != 4'h0 |-> bad_cnt >= PG_FILT_CYC - 2)
      else $error("reset pulled low too early");
   a_release_after_good: assert property ($fell(pfail_rst_oe_o) |-> good_cnt >= RST_CYC - 2)
      else $error("reset released too early");
   a_all_off_low: assert property (channel_on_o == 4'h0 [*2] |-> pfail_rst_oe_o)
      else $error("reset released with all channels off");
   a_ot_gates_on: assert property (overtemp_shutdown_o |-> channel_on_o == 4'h0)
      else $error("channel on during overtemp");
   a_ot_hold_lo: assert property (overtemp_lo_i [*5] ##0 overtemp_shutdown_o
      |=> overtemp_shutdown_o)
      else $error("overtemp cleared above lower trip");
   a_temp_mon_off: assert property (channel_on_o == 4'h0 [*5] |-> !temp_mon_en_o && !temp_oe_o)
      else $error("temperature monitor on with channels off");
   a_wdo_low_len: assert property ($rose(watchdog_timeout_out_o)
      |-> low_cnt >= WD_BASE_CYC - 2)
      else $error("watchdog low period too short");
   c_release: cover property ($fell(pfail_rst_oe_o));
   c_overtemp: cover property ($rose(overtemp_shutdown_o));
   c_wd_trip: cover property ($fell(watchdog_timeout_out_o));
endmodule // lvs_supervisor_asserts

bind lvs_supervisor lvs_supervisor_asserts #(.RST_CYC(RST_CYC), .WD_BASE_CYC(WD_BASE_CYC)) u_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .fb_under_i(fb_under_i), .fb_over_i(fb_over_i),
   .overtemp_lo_i(overtemp_lo_i), .precise_threshold_o(precise_threshold_o),
   .channel_on_o(channel_on_o), .power_good_o(power_good_o), .pfail_rst_oe_o(pfail_rst_oe_o),
   .overtemp_shutdown_o(overtemp_shutdown_o), .temp_mon_en_o(temp_mon_en_o),
   .temp_oe_o(temp_oe_o), .watchdog_timeout_out_o(watchdog_timeout_out_o));

/* File: test/lvs_mcu_model.sv */
// Model of the processor that services the watchdog
`timescale 1ns/1ps
module lvs_mcu_model (
   input wire logic sys_clk_i,
   input wire logic kick_en_i,
   input wire logic [15:0] period_i,
   output logic kick_o
);
   logic [15:0] cnt_reg;
   initial kick_o = 1'b1;
   initial cnt_reg = 16'h0000;
   // Low pulse of six cycles each period: one falling edge per service
   always @(posedge sys_clk_i) begin
      if (!kick_en_i) begin
         cnt_reg <= 16'h0000;
         kick_o <= 1'b1;
      end else begin
         cnt_reg <= (cnt_reg >= period_i) ? 16'h0000 : cnt_reg + 16'h0001;
         if (cnt_reg >= period_i) kick_o <= 1'b0;
         else if (cnt_reg == 16'h0005) kick_o <= 1'b1;
      end
   end
endmodule // lvs_mcu_model

/* File: test/lvs_supervisor_test.sv */
// Self-checking bench for the supervisor
`timescale 1ns/1ps
module lvs_supervisor_test import lvs_pkg::*; ;
   localparam int BIAS = 40;
   localparam int RST = 400;
   localparam int WDB = 400;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic run_i = 1'b0;
   logic [3:0] en = 4'h0;
   logic [3:0] under = 4'h0;
   logic [3:0] over = 4'h0;
   logic ot_hi = 1'b0;
   logic ot_lo = 1'b0;
   logic kick_en = 1'b0;
   logic [15:0] period = 16'h00C8;
   logic kick, thr, rst_n, oe, ots, tme, toe, watchdog_timeout_out;
   logic [3:0] on, ssg, pg;
   int errors = 0;
   int compares = 0;
   // ----
   // Clock, design and processor model
   // ----
   initial forever #5 sys_clk_i = ~sys_clk_i;
   lvs_supervisor #(.BIAS_CYC(BIAS), .RST_CYC(RST), .WD_BASE_CYC(WDB)) u_dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1), .run_i(run_i),
      .channel_enable_inputs_i(en), .fb_under_i(under), .fb_over_i(over),
      .overtemp_hi_i(ot_hi), .overtemp_lo_i(ot_lo), .ct_tied_bias_i(1'b0),
      .watchdog_kick_in_i(kick), .precise_threshold_o(thr), .channel_on_o(on),
      .soft_start_go_o(ssg), .power_good_o(pg), .pfail_rst_n_o(rst_n), .pfail_rst_oe_o(oe),
      .overtemp_shutdown_o(ots), .temp_mon_en_o(tme), .temp_oe_o(toe),
      .watchdog_timeout_out_o(watchdog_timeout_out));
   lvs_mcu_model u_mcu (.sys_clk_i(sys_clk_i), .kick_en_i(kick_en), .period_i(period),
      .kick_o(kick));
   // Edges for driving; see() lets the edge's updates land before looking
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic see(input int n);
      cyc(n);
      #1;
   endtask
   task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Bounded wait for the watchdog output to reach a level
   task automatic wait_wdo(input logic v, input int n);
      for (int i = 0; i < n && watchdog_timeout_out !== v; i++) see(1);
      chk("wdo", {3'h0, v}, {3'h0, watchdog_timeout_out});
   endtask
   task automatic t_start();
      see(1);
      chk("oe", 4'h1, {3'h0, oe});
      chk("wdo", 4'h0, {3'h0, watchdog_timeout_out});
      chk("rst_n", 4'h0, {3'h0, rst_n});
      cyc(1);
      run_i <= 1'b1;
      en <= 4'hF;
      see(BIAS / 2);
      chk("on", 4'h0, on);
      chk("thr", 4'h0, {3'h0, thr});
      see(BIAS);
      chk("on", 4'hF, on);
      chk("thr", 4'h1, {3'h0, thr});
      chk("oe", 4'h1, {3'h0, oe});
      see(SS_DELAY_CYC - 100);
      chk("ssg", 4'h0, ssg);
      see(200);
      chk("ssg", 4'hF, ssg);
      chk("oe", 4'h0, {3'h0, oe});
      $display("test start done");
   endtask
   task automatic t_wd();
      chk("wdo", 4'h1, {3'h0, watchdog_timeout_out});
      cyc(1);
      kick_en <= 1'b1;
      see(3000);
      chk("wdo", 4'h1, {3'h0, watchdog_timeout_out});
      cyc(1);
      period <= 16'h0032;
      wait_wdo(1'b0, 300);
      cyc(1);
      kick_en <= 1'b0;
      see(WDB - 20);
      chk("wdo", 4'h0, {3'h0, watchdog_timeout_out});
      wait_wdo(1'b1, 40);
      see(WD_TMO_MULT * WDB - 60);
      chk("wdo", 4'h1, {3'h0, watchdog_timeout_out});
      wait_wdo(1'b0, 120);
      $display("test watchdog done");
   endtask
   task automatic t_pg();
      cyc(1);
      under <= 4'h1;
      see(5);
      chk("pg", 4'hE, pg);
      see(PG_FILT_CYC - 300);
      chk("oe", 4'h0, {3'h0, oe});
      cyc(1);
      under <= 4'h0;
      see(10);
      chk("pg", 4'hF, pg);
      cyc(1);
      over <= 4'h8;
      see(5);
      chk("pg", 4'h7, pg);
      see(PG_FILT_CYC - 300);
      chk("oe", 4'h0, {3'h0, oe});
      see(350);
      chk("oe", 4'h1, {3'h0, oe});
      cyc(1);
      over <= 4'h0;
      see(RST - 50);
      chk("oe", 4'h1, {3'h0, oe});
      see(100);
      chk("oe", 4'h0, {3'h0, oe});
      $display("test power fail done");
   endtask
   task automatic t_ot();
      cyc(1);
      ot_hi <= 1'b1;
      ot_lo <= 1'b1;
      see(6);
      chk("ots", 4'h1, {3'h0, ots});
      chk("on", 4'h0, on);
      cyc(1);
      ot_hi <= 1'b0;
      see(20);
      chk("ots", 4'h1, {3'h0, ots});
      chk("oe", 4'h1, {3'h0, oe});
      chk("temp", 4'h0, {2'h0, tme, toe});
      cyc(1);
      ot_lo <= 1'b0;
      see(6);
      chk("ots", 4'h0, {3'h0, ots});
      chk("on", 4'hF, on);
      $display("test overtemp done");
   endtask
   task automatic complete_run();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence after three cycles of reset
   initial begin
      cyc(3);
      rst_i <= 1'b0;
      t_start();
      t_wd();
      t_pg();
      t_ot();
      complete_run();
   end
   // Hang guard well past the expected run of about 64500 cycles
   initial begin
      #900_000;
      errors++;
      complete_run();
   end
endmodule // lvs_supervisor_test
